// ===== rtl/pio_pkg.sv
package pio_pkg;

  // port geometry
  localparam int NUM_PORTS = 7;
  localparam int PORT_W    = 8;
  localparam int IMC_PORTS = 3;
  localparam int PD_W      = 4;

  // port indices, in pin order a..g
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;
  localparam int PORT_G = 6;

  // register window address layout: {port[2:0], reg[2:0]}
  localparam int ADDR_W        = 6;
  localparam int ADDR_PORT_LSB = 3;
  localparam int ADDR_PORT_W   = 3;
  localparam int ADDR_REG_W    = 3;

  // register selects within one port
  localparam logic [ADDR_REG_W-1:0] REG_PIN_IN    = 3'h0;
  localparam logic [ADDR_REG_W-1:0] REG_OUT_VALUE = 3'h1;
  localparam logic [ADDR_REG_W-1:0] REG_DIRECTION = 3'h2;
  localparam logic [ADDR_REG_W-1:0] REG_DRIVE_SEL = 3'h3;
  localparam logic [ADDR_REG_W-1:0] REG_OE_STATE  = 3'h4;
  localparam logic [ADDR_REG_W-1:0] REG_IMC_OUT   = 3'h5;
  localparam logic [ADDR_REG_W-1:0] REG_MCELL_OUT = 3'h6;

  // reset values: all pins input, push-pull, standard slew
  localparam logic [PORT_W-1:0] RST_OUT_VALUE = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIRECTION = 8'h00;
  localparam logic [PORT_W-1:0] RST_DRIVE_SEL = 8'h00;
  localparam logic [PORT_W-1:0] RST_RDATA     = 8'h00;

  // pins present on the narrow port
  localparam logic [PORT_W-1:0] PORT_D_MASK = 8'h0F;
  localparam logic [PORT_W-1:0] FULL_MASK   = 8'hFF;

  // narrow-port dedicated pin positions
  localparam int PD_CLK_BIT = 1;
  localparam int PD_CS_BIT  = 2;
  localparam int PD_WRH_BIT = 3;

  // input macrocell behaviour
  typedef enum logic [1:0] {
    IMC_DIRECT,
    IMC_REGISTER,
    IMC_LATCH
  } pio_imc_mode_t;

  // per-port pin configuration, fixed by the configuration image
  typedef struct packed {
    logic [PORT_W-1:0] logic_owned;  // output mux takes the logic array
    logic [PORT_W-1:0] oe_pt_def;    // enable product term exists
    logic [PORT_W-1:0] dedicated;    // pin taken by another function
  } pio_pin_cfg_t;

  // processor bus request into the register window
  typedef struct packed {
    logic              window_sel;
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
  } pio_bus_req_t;

endpackage : pio_pkg

// ===== rtl/pio_imc_bank.sv
`timescale 1ns/1ps
module pio_imc_bank
  import pio_pkg::*;
#(
  parameter int W = pio_pkg::PORT_W
) (
  input  wire logic                            mclk_i,
  input  wire logic                            sys_rst_i,
  input  wire pio_pkg::pio_imc_mode_t [W-1:0]  mode_i,
  input  wire logic                            pt_clk_i,
  input  wire logic [W-1:0]                    d_i,
  output logic      [W-1:0]                    q_o
);
  import pio_pkg::*;

  logic         pt_q;
  logic [W-1:0] reg_q;
  logic [W-1:0] lat_q;

  // product-term history; the term is a gate, not a real clock
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) pt_q <= 1'b0;
    else           pt_q <= pt_clk_i;
  end

  // sampling register loads on the rising product term
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)              reg_q <= '0;
    else if (pt_clk_i && !pt_q) reg_q <= d_i;
  end

  // latch holds what it saw while the term was open
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)     lat_q <= '0;
    else if (pt_clk_i) lat_q <= d_i;
  end

  // per-pin selection of the macrocell flavour
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      unique case (mode_i[i])
        IMC_REGISTER: q_o[i] = reg_q[i];
        IMC_LATCH:    q_o[i] = pt_clk_i ? d_i[i] : lat_q[i];
        IMC_DIRECT:   q_o[i] = d_i[i];
        default:      q_o[i] = d_i[i];
      endcase
    end
  end

endmodule : pio_imc_bank

// ===== rtl/pio_ports.sv
`timescale 1ns/1ps
// Summary of operation
// - seven ports, eight pins, narrow port four
// - output mux picks register, macrocell or select
// - driver enable is product term OR direction
// - without product term direction alone drives
// - read-back puts exactly one source on bus
// - first three ports: register, latch or direct
// - input macrocells clocked by logic product term
// - pin input read returns actual pin level
// - output bit drives pin unless logic owns
// - output register readable; writable except sixth port and 16-bit seventh
// - direction one is output; reset input
// - drive bit one gives open drain
// - drive bit one gives fast slew
// - third port slew; first, second, fifth and 8-bit seventh open drain
// - read-only register shows actual driver enables
// - sixth port low data; seventh high data
// - seventh port general use only eight-bit
// - narrow port feeds logic array directly
// - macrocell groups a, b and selects
// - chip-select input high disables the window
// - narrow pins as logic clock, write strobe
// - assigned pins serve no other purpose; code only masks their drivers, narrow ones still feed logic array
module pio_ports
  import pio_pkg::*;
#(
  parameter int NP = pio_pkg::NUM_PORTS,
  parameter int PW = pio_pkg::PORT_W,
  parameter int NI = pio_pkg::IMC_PORTS
) (
  input  wire logic                                 mclk_i,
  input  wire logic                                 sys_rst_i,
  input  wire pio_pkg::pio_bus_req_t                bus_i,
  input  wire logic                                 bus16_cfg_i,
  input  wire pio_pkg::pio_pin_cfg_t [NP-1:0]       pin_cfg_i,
  input  wire logic [NP-1:0][PW-1:0]                oe_pt_i,
  input  wire pio_pkg::pio_imc_mode_t [NI-1:0][PW-1:0] imc_mode_i,
  input  wire logic [NI-1:0]                        imc_pt_clk_i,
  input  wire logic [PW-1:0]                        mcell_a_i,
  input  wire logic [PW-1:0]                        mcell_b_i,
  input  wire logic [PW-1:0]                        ext_cs_i,
  input  wire logic                                 pd_clk_en_i,
  input  wire logic                                 pd_cs_en_i,
  input  wire logic                                 pd_wrh_en_i,
  input  wire logic [NP-1:0][PW-1:0]                pad_in_i,
  output logic      [NP-1:0][PW-1:0]                pad_out_o,
  output logic      [NP-1:0][PW-1:0]                pad_oe_o,
  output logic      [PW-1:0]                        fast_slew_o,
  output logic      [NI-1:0][PW-1:0]                logic_in_imc_o,
  output logic      [PD_W-1:0]                      logic_in_direct_o,
  output logic                                      logic_clock_o,
  output logic                                      high_byte_wr_o,
  output logic                                      mem_disable_o
);
  import pio_pkg::*;

  logic [NP-1:0][PW-1:0] out_q;
  logic [NP-1:0][PW-1:0] dir_q;
  logic [NP-1:0][PW-1:0] drv_q;
  logic [PW-1:0]         rdata_q;
  logic                  bus_drive_q;
  logic [NP-1:0][PW-1:0] drive_en;
  logic [NP-1:0][PW-1:0] pin_val;
  logic [NP-1:0][PW-1:0] od_sel;
  logic [NP-1:0][PW-1:0] alt_src;
  logic [NP-1:0][PW-1:0] ded_mask;
  logic [NP-1:0][PW-1:0] imc_rb;
  logic [PW-1:0]         wdata;
  logic [PW-1:0]         rb_data;
  logic                  window_off;
  logic                  window_hit;
  logic [ADDR_PORT_W-1:0] acc_port;
  logic [ADDR_REG_W-1:0]  acc_reg;

  // pins physically present on each port
  function automatic logic [PW-1:0] port_mask(input int p);
    return (p == PORT_D) ? PORT_D_MASK : FULL_MASK;
  endfunction : port_mask

  // one write decoder shared by all writable registers
  function automatic logic wr_hit(input logic                   hit,
                                  input logic                   wr,
                                  input logic [ADDR_PORT_W-1:0] port,
                                  input logic [ADDR_REG_W-1:0]  rsel,
                                  input int                     p,
                                  input logic [ADDR_REG_W-1:0]  want,
                                  input logic                   b16);
    logic ok;
    ok = (p != PORT_F) && !((p == PORT_G) && b16);
    return hit && wr && ok && (port == ADDR_PORT_W'(p)) && (rsel == want);
  endfunction : wr_hit

  // chip-select pin on the narrow port shuts the window off
  assign window_off    = pd_cs_en_i && pad_in_i[PORT_D][PD_CS_BIT];
  assign mem_disable_o = window_off;
  assign window_hit    = bus_i.window_sel && !window_off;
  assign acc_port      = bus_i.addr[ADDR_PORT_LSB +: ADDR_PORT_W];
  assign acc_reg       = bus_i.addr[ADDR_REG_W-1:0];

  // processor low data byte arrives on the sixth port
  assign wdata = pad_in_i[PORT_F];

  // dedicated narrow-port inputs routed to their consumers
  assign logic_clock_o     = pd_clk_en_i && pad_in_i[PORT_D][PD_CLK_BIT];
  assign high_byte_wr_o    = pd_wrh_en_i && bus16_cfg_i && pad_in_i[PORT_D][PD_WRH_BIT];
  assign logic_in_direct_o = pad_in_i[PORT_D][PD_W-1:0];

  // output value registers, one per port
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      out_q <= {NP{RST_OUT_VALUE}};
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (wr_hit(window_hit, bus_i.wr, acc_port, acc_reg, p, REG_OUT_VALUE, bus16_cfg_i)) begin
          out_q[p] <= wdata & port_mask(p);
        end
      end
    end
  end

  // direction registers; reset leaves every pin an input
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dir_q <= {NP{RST_DIRECTION}};
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (wr_hit(window_hit, bus_i.wr, acc_port, acc_reg, p, REG_DIRECTION, bus16_cfg_i)) begin
          dir_q[p] <= wdata & port_mask(p);
        end
      end
    end
  end

  // drive-select registers; default is push-pull, standard slew
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      drv_q <= {NP{RST_DRIVE_SEL}};
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (wr_hit(window_hit, bus_i.wr, acc_port, acc_reg, p, REG_DRIVE_SEL, bus16_cfg_i)) begin
          drv_q[p] <= wdata & port_mask(p);
        end
      end
    end
  end

  // input macrocells on the first three ports
  for (genvar p = 0; p < NI; p++) begin : g_imc
    pio_imc_bank #(
      .W (PW)
    ) u_imc (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .mode_i    (imc_mode_i[p]),
      .pt_clk_i  (imc_pt_clk_i[p]),
      .d_i       (pad_in_i[p]),
      .q_o       (logic_in_imc_o[p])
    );
  end

  // per-port pin logic
  for (genvar p = 0; p < NP; p++) begin : g_port

    // alternate output source of each port
    if (p == PORT_A) begin : g_alt_a
      assign alt_src[p] = mcell_a_i;
    end else if (p == PORT_B) begin : g_alt_b
      assign alt_src[p] = mcell_b_i;
    end else if (p == PORT_C) begin : g_alt_c
      assign alt_src[p] = ext_cs_i;
    end else begin : g_alt_none
      assign alt_src[p] = '0;
    end

    // macrocell read-back only exists where the cells do
    if (p < NI) begin : g_imc_rb
      assign imc_rb[p] = logic_in_imc_o[p];
    end else begin : g_no_imc_rb
      assign imc_rb[p] = '0;
    end

    // narrow-port dedicated pins join the configured ones
    if (p == PORT_D) begin : g_ded_d
      assign ded_mask[p] = pin_cfg_i[p].dedicated
                         | (PW'(pd_clk_en_i) << PD_CLK_BIT)
                         | (PW'(pd_cs_en_i)  << PD_CS_BIT)
                         | (PW'(pd_wrh_en_i) << PD_WRH_BIT);
    end else begin : g_ded
      assign ded_mask[p] = pin_cfg_i[p].dedicated;
    end

    // open drain only on ports whose drive bits mean that
    if (p == PORT_A || p == PORT_B || p == PORT_E) begin : g_od
      assign od_sel[p] = drv_q[p];
    end else if (p == PORT_G) begin : g_od_g
      assign od_sel[p] = bus16_cfg_i ? '0 : drv_q[p];
    end else begin : g_no_od
      assign od_sel[p] = '0;
    end

    // data-bus ports are owned by the read path
    if (p == PORT_F) begin : g_bus_lo
      assign pin_val[p]  = rdata_q;
      assign drive_en[p] = {PW{bus_drive_q}};
    end else if (p == PORT_G) begin : g_bus_hi
      // high byte reads as zero; registers are only a byte wide
      assign pin_val[p]  = bus16_cfg_i ? '0 : out_q[p];
      assign drive_en[p] = bus16_cfg_i ? {PW{bus_drive_q}}
                         : ((dir_q[p] | (pin_cfg_i[p].oe_pt_def & oe_pt_i[p])) & ~ded_mask[p]);
    end else begin : g_gpio
      // logic ownership overrides the written value
      assign pin_val[p]  = (pin_cfg_i[p].logic_owned & alt_src[p])
                         | (~pin_cfg_i[p].logic_owned & out_q[p]);
      // product term ORed in only where one is defined
      assign drive_en[p] = (dir_q[p] | (pin_cfg_i[p].oe_pt_def & oe_pt_i[p]))
                         & ~ded_mask[p] & port_mask(p);
    end

    // open drain only pulls low; a high releases the pin
    assign pad_oe_o[p]  = drive_en[p] & (~od_sel[p] | ~pin_val[p]);
    assign pad_out_o[p] = pin_val[p] & ~od_sel[p];
  end

  // slew control is the third port's use of its drive bits
  assign fast_slew_o = drv_q[PORT_C];

  // read-back buffer: exactly one source per access
  always_comb begin
    rb_data = '0;
    for (int p = 0; p < NP; p++) begin
      if (acc_port == ADDR_PORT_W'(p)) begin
        unique case (acc_reg)
          REG_PIN_IN:    rb_data = pad_in_i[p] & port_mask(p);
          REG_OUT_VALUE: rb_data = out_q[p];
          REG_DIRECTION: rb_data = dir_q[p];
          REG_DRIVE_SEL: rb_data = drv_q[p];
          REG_OE_STATE:  rb_data = pad_oe_o[p] & port_mask(p);
          REG_IMC_OUT:   rb_data = imc_rb[p];
          REG_MCELL_OUT: rb_data = alt_src[p];
          default:       rb_data = '0;
        endcase
      end
    end
  end

  // read data captured from flops; bus driven the cycle after
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_q     <= RST_RDATA;
      bus_drive_q <= 1'b0;
    end else begin
      bus_drive_q <= window_hit && bus_i.rd;
      if (window_hit && bus_i.rd) begin
        rdata_q <= rb_data;
      end
    end
  end

endmodule : pio_ports

// ===== tb/pio_ports_properties.sv
`timescale 1ns/1ps
module pio_ports_properties
  import pio_pkg::*;
#(
  parameter int NP = pio_pkg::NUM_PORTS,
  parameter int PW = pio_pkg::PORT_W
) (
  input wire logic                           mclk_i,
  input wire logic                           sys_rst_i,
  input wire pio_pkg::pio_bus_req_t          bus_i,
  input wire pio_pkg::pio_pin_cfg_t [NP-1:0] pin_cfg_i,
  input wire logic [NP-1:0][PW-1:0]          oe_pt_i,
  input wire logic [PW-1:0]                  ext_cs_i,
  input wire logic                           pd_cs_en_i,
  input wire logic [NP-1:0][PW-1:0]          pad_in_i,
  input wire logic [NP-1:0][PW-1:0]          pad_out_o,
  input wire logic [NP-1:0][PW-1:0]          pad_oe_o,
  input wire logic [PW-1:0]                  fast_slew_o,
  input wire logic [PD_W-1:0]                logic_in_direct_o,
  input wire logic                           mem_disable_o
);
  // window is refused while the narrow-port select pin is high
  logic blk;
  logic take;
  assign blk  = pd_cs_en_i & pad_in_i[PORT_D][PD_CS_BIT];
  assign take = bus_i.window_sel & ~blk;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  AST_RD_OE: assert property (
    take && bus_i.rd |=> pad_oe_o[PORT_F] == 8'hFF)
    else $error("read data not driven on data port");
  AST_RST_DIR: assert property (
    $fell(sys_rst_i) |-> (pad_oe_o[PORT_E] & ~oe_pt_i[PORT_E]) == 8'h00)
    else $error("pin driven right after reset");
  AST_DED_OE: assert property (
    (pad_oe_o[PORT_C] & pin_cfg_i[PORT_C].dedicated) == 8'h00)
    else $error("dedicated pin driven");
  AST_PT_OE: assert property (
    (pin_cfg_i[PORT_C].oe_pt_def & oe_pt_i[PORT_C] & ~pin_cfg_i[PORT_C].dedicated & ~pad_oe_o[PORT_C]) == 8'h00)
    else $error("product term failed to enable driver");
  AST_CS_MUX: assert property (
    (pad_oe_o[PORT_C] & pin_cfg_i[PORT_C].logic_owned & (pad_out_o[PORT_C] ^ ext_cs_i)) == 8'h00)
    else $error("chip select not routed to pin");
  AST_SLEW_WR: assert property (
    take && bus_i.wr && bus_i.addr == {3'h2, REG_DRIVE_SEL} |=> fast_slew_o == $past(pad_in_i[PORT_F]))
    else $error("slew register write not applied");
  AST_CS_HOLD: assert property (
    !sys_rst_i && bus_i.window_sel && blk |=> $stable(fast_slew_o))
    else $error("access taken while deselected");
  AST_MEM_DIS: assert property (
    mem_disable_o == blk)
    else $error("memory disable does not follow select pin");
  AST_DIRECT: assert property (
    logic_in_direct_o == pad_in_i[PORT_D][PD_W-1:0])
    else $error("narrow port not passed to logic array");

  cover property (take && bus_i.rd);
  cover property (bus_i.window_sel && blk);
  cover property (take && bus_i.wr && bus_i.addr == {3'h2, REG_DRIVE_SEL});
endmodule : pio_ports_properties

// ===== tb/pio_pin_model.sv
`timescale 1ns/1ps
module pio_pin_model
  import pio_pkg::*;
(
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] pad_out_i,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] pad_oe_i,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] ext_val_i,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] ext_en_i,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0] pad_in_o
);
  // wire level: chip, else outside driver, else board pull-up
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int b = 0; b < PORT_W; b++) begin
        pad_in_o[p][b] = pad_oe_i[p][b] ? pad_out_i[p][b] : (ext_en_i[p][b] ? ext_val_i[p][b] : 1'b1);
      end
    end
  end
endmodule : pio_pin_model

// ===== tb/tb_programmable_io_ports.sv
`timescale 1ns/1ps
module tb_programmable_io_ports;
  import pio_pkg::*;
  typedef logic [NUM_PORTS-1:0][PORT_W-1:0] pio_pins_t;
  logic                                      mclk_i, sys_rst_i, bus16_cfg_i;
  pio_bus_req_t                              bus_i;
  pio_pin_cfg_t [NUM_PORTS-1:0]              pin_cfg_i;
  pio_pins_t                                 oe_pt_i, ext_val, ext_en, pad_in_i, pad_out_o, pad_oe_o;
  pio_imc_mode_t [IMC_PORTS-1:0][PORT_W-1:0] imc_mode_i;
  logic [IMC_PORTS-1:0]                      imc_pt_clk_i;
  logic [IMC_PORTS-1:0][PORT_W-1:0]          logic_in_imc_o;
  logic [PORT_W-1:0]                         mcell_a_i, mcell_b_i, ext_cs_i, fast_slew_o;
  logic                                      pd_clk_en_i, pd_cs_en_i, pd_wrh_en_i;
  logic [PD_W-1:0]                           logic_in_direct_o;
  logic                                      logic_clock_o, high_byte_wr_o, mem_disable_o;
  int                                        n_mismatch, total_checks;

  pio_ports dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .bus16_cfg_i(bus16_cfg_i),
    .pin_cfg_i(pin_cfg_i), .oe_pt_i(oe_pt_i), .imc_mode_i(imc_mode_i), .imc_pt_clk_i(imc_pt_clk_i),
    .mcell_a_i(mcell_a_i), .mcell_b_i(mcell_b_i), .ext_cs_i(ext_cs_i), .pd_clk_en_i(pd_clk_en_i),
    .pd_cs_en_i(pd_cs_en_i), .pd_wrh_en_i(pd_wrh_en_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o), .fast_slew_o(fast_slew_o), .logic_in_imc_o(logic_in_imc_o),
    .logic_in_direct_o(logic_in_direct_o), .logic_clock_o(logic_clock_o),
    .high_byte_wr_o(high_byte_wr_o), .mem_disable_o(mem_disable_o));

  pio_pin_model u_pins (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_val_i(ext_val),
                        .ext_en_i(ext_en), .pad_in_o(pad_in_i));

  // 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // write data rides in on the data port pins, held until the taking edge
  task automatic wr(input logic [2:0] p, input logic [2:0] r, input logic [7:0] d);
    @(posedge mclk_i);
    bus_i <= '{1'b1, 1'b0, 1'b1, {p, r}};
    ext_val[PORT_F] <= d;
    ext_en[PORT_F] <= 8'hFF;
    @(posedge mclk_i);
    bus_i <= '0;
    ext_en[PORT_F] <= 8'h00;
  endtask : wr

  // read answer stands just after the taking edge, checked 1 ns later
  task automatic rchk(input logic [2:0] p, input logic [2:0] r, input logic [7:0] exp);
    @(posedge mclk_i);
    bus_i <= '{1'b1, 1'b1, 1'b0, {p, r}};
    @(posedge mclk_i);
    bus_i <= '0;
    #1 check(pad_out_o[PORT_F], exp);
  endtask : rchk

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // hang guard
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {sys_rst_i, bus16_cfg_i, bus_i, pin_cfg_i, oe_pt_i, ext_val, ext_en} = '0;
    {imc_pt_clk_i, mcell_a_i, mcell_b_i, ext_cs_i, pd_clk_en_i, pd_cs_en_i, pd_wrh_en_i} = '0;
    imc_mode_i = '{default: IMC_DIRECT};
    sys_rst_i = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    // reset values, then write and read back every general port
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (p != PORT_F) begin
        rchk(3'(p), REG_OUT_VALUE, 8'h00);
        rchk(3'(p), REG_DIRECTION, 8'h00);
        rchk(3'(p), REG_DRIVE_SEL, 8'h00);
        rchk(3'(p), REG_OE_STATE, 8'h00);
        wr(3'(p), REG_OUT_VALUE, 8'hA5);
        rchk(3'(p), REG_OUT_VALUE, (p == PORT_D) ? 8'h05 : 8'hA5);
      end
    end
    // high byte lane owns port G in 16-bit mode; port F is bus only
    @(posedge mclk_i);
    bus16_cfg_i <= 1'b1;
    wr(3'(PORT_G), REG_OUT_VALUE, 8'h3C);
    bus16_cfg_i <= 1'b0;
    rchk(3'(PORT_G), REG_OUT_VALUE, 8'hA5);
    wr(3'(PORT_F), REG_DIRECTION, 8'hFF);
    #1 check(pad_oe_o[PORT_F], 8'h00);
    // drive port E so the mid-run reset has something to undo
    wr(3'(PORT_E), REG_DIRECTION, 8'hFF);
    // second reset in mid-run
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rchk(3'(PORT_E), REG_OUT_VALUE, 8'h00);
    rchk(3'(PORT_E), REG_DIRECTION, 8'h00);
    // port E push-pull, then open drain, then input
    wr(3'(PORT_E), REG_OUT_VALUE, 8'hA5);
    wr(3'(PORT_E), REG_DIRECTION, 8'hFF);
    #1 check(pad_oe_o[PORT_E], 8'hFF);
    check(pad_out_o[PORT_E], 8'hA5);
    rchk(3'(PORT_E), REG_PIN_IN, 8'hA5);
    wr(3'(PORT_E), REG_DRIVE_SEL, 8'hFF);
    #1 check(pad_oe_o[PORT_E], 8'h5A);
    rchk(3'(PORT_E), REG_OE_STATE, 8'h5A);
    rchk(3'(PORT_E), REG_PIN_IN, 8'hA5);
    wr(3'(PORT_E), REG_DIRECTION, 8'h00);
    ext_val[PORT_E] <= 8'h3C;
    ext_en[PORT_E] <= 8'hFF;
    rchk(3'(PORT_E), REG_PIN_IN, 8'h3C);
    // port C drive bits set slew, never open drain
    wr(3'(PORT_C), REG_DRIVE_SEL, 8'hC3);
    #1 check(fast_slew_o, 8'hC3);
    wr(3'(PORT_C), REG_OUT_VALUE, 8'h0F);
    wr(3'(PORT_C), REG_DIRECTION, 8'hFF);
    #1 check(pad_oe_o[PORT_C], 8'hFF);
    check(pad_out_o[PORT_C], 8'h0F);
    // logic array takes the output mux
    @(posedge mclk_i);
    pin_cfg_i[PORT_C].logic_owned <= 8'hFF;
    ext_cs_i <= 8'h96;
    #1 check(pad_out_o[PORT_C], 8'h96);
    rchk(3'(PORT_C), REG_OUT_VALUE, 8'h0F);
    rchk(3'(PORT_C), REG_MCELL_OUT, 8'h96);
    wr(3'(PORT_A), REG_DIRECTION, 8'hFF);
    pin_cfg_i[PORT_A].logic_owned <= 8'hFF;
    mcell_a_i <= 8'h69;
    #1 check(pad_out_o[PORT_A], 8'h69);
    // enable product term against direction and dedication
    wr(3'(PORT_C), REG_DIRECTION, 8'h00);
    oe_pt_i[PORT_C] <= 8'hFF;
    #1 check(pad_oe_o[PORT_C], 8'h00);
    @(posedge mclk_i);
    pin_cfg_i[PORT_C].oe_pt_def <= 8'hFF;
    pin_cfg_i[PORT_C].dedicated <= 8'h01;
    #1 check(pad_oe_o[PORT_C], 8'hFE);
    // input macrocells: register on the term's rise, latch, pass
    @(posedge mclk_i);
    imc_mode_i[PORT_B] <= '{default: IMC_REGISTER};
    ext_val[PORT_B] <= 8'h55;
    ext_en[PORT_B] <= 8'hFF;
    repeat (2) @(posedge mclk_i);
    imc_pt_clk_i[PORT_B] <= 1'b1;
    repeat (3) @(posedge mclk_i);
    ext_val[PORT_B] <= 8'hAA;
    repeat (3) @(posedge mclk_i);
    #1 check(logic_in_imc_o[PORT_B], 8'h55);
    rchk(3'(PORT_B), REG_IMC_OUT, 8'h55);
    @(posedge mclk_i);
    imc_mode_i[PORT_B] <= '{default: IMC_LATCH};
    repeat (3) @(posedge mclk_i);
    #1 check(logic_in_imc_o[PORT_B], 8'hAA);
    @(posedge mclk_i);
    imc_pt_clk_i[PORT_B] <= 1'b0;
    repeat (2) @(posedge mclk_i);
    ext_val[PORT_B] <= 8'h0F;
    repeat (3) @(posedge mclk_i);
    #1 check(logic_in_imc_o[PORT_B], 8'hAA);
    @(posedge mclk_i);
    imc_mode_i[PORT_B] <= '{default: IMC_DIRECT};
    repeat (2) @(posedge mclk_i);
    #1 check(logic_in_imc_o[PORT_B], 8'h0F);
    // narrow port: direct inputs, clock and strobe pins, chip select
    @(posedge mclk_i);
    ext_val[PORT_D] <= 8'h0A;
    ext_en[PORT_D] <= 8'h0F;
    pd_clk_en_i <= 1'b1;
    pd_wrh_en_i <= 1'b1;
    bus16_cfg_i <= 1'b1;   // strobe pin only counts on a 16-bit bus
    #1 check({4'h0, logic_in_direct_o}, 8'h0A);
    check({6'h00, logic_clock_o, high_byte_wr_o}, 8'h03);
    @(posedge mclk_i);
    pd_cs_en_i <= 1'b1;
    ext_val[PORT_D] <= 8'h0E;
    #1 check({7'h00, mem_disable_o}, 8'h01);
    wr(3'(PORT_C), REG_DRIVE_SEL, 8'h00);
    #1 check(fast_slew_o, 8'hC3);
    @(posedge mclk_i);
    pd_cs_en_i <= 1'b0;
    rchk(3'(PORT_C), REG_DRIVE_SEL, 8'hC3);
    check(pad_oe_o[PORT_G], 8'hFF);
    print_verdict();
  end
endmodule : tb_programmable_io_ports

bind pio_ports pio_ports_properties #(.NP(NP), .PW(PW)) u_props (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .pin_cfg_i(pin_cfg_i), .oe_pt_i(oe_pt_i),
  .ext_cs_i(ext_cs_i), .pd_cs_en_i(pd_cs_en_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
  .pad_oe_o(pad_oe_o), .fast_slew_o(fast_slew_o), .logic_in_direct_o(logic_in_direct_o),
  .mem_disable_o(mem_disable_o));
